/* src/bsxa_pkg.sv */
package bsxa_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned NIB_LO      = 3;
  localparam int unsigned NIB_HI      = 4;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [2:0]  FLAGS_RST   = 3'h0;
  localparam logic [6:0]  ADDR_MAX    = 7'h7f;
  localparam int unsigned REGFILE_DEP = 128;

  typedef enum logic [2:0] {
    BSXA_OP_NONE,
    BSXA_OP_SUB_LIT,
    BSXA_OP_XOR_LIT,
    BSXA_OP_SUB_REG,
    BSXA_OP_XOR_REG,
    BSXA_OP_SWAP
  } bsxa_op_t;

  typedef struct packed {
    logic        arith_out_flag;
    logic        nibble_flag;
    logic        all_bits_low_flag;
  } bsxa_flags_t;

  typedef struct packed {
    logic        valid;
    bsxa_op_t    op;
    logic [7:0]  literal_value;
    logic [6:0]  reg_addr;
    logic        target_bit;
  } bsxa_cmd_t;

  typedef struct packed {
    logic        wr_en;
    logic [6:0]  addr;
    logic [7:0]  data;
  } bsxa_wb_t;

endpackage

/* src/bsxa_regfile.sv */
module bsxa_regfile
  import bsxa_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire bsxa_pkg::bsxa_wb_t wr,
  input  wire logic [6:0]        rd_addr,
  output logic [7:0]             rd_data_ff
);

  // Storage has no reset; only the registered read port is cleared.
  logic [7:0] mem [REGFILE_DEP];
  logic [7:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = mem[rd_addr];
  end

  always_ff @(posedge sys_clk) begin
    if (wr.wr_en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= ACC_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

endmodule

/* src/bsxa_alu.sv */
// What this block does
// - Literal minus accumulator goes to accumulator; updates carry, nibble and zero flags.
// - Accumulator XOR literal goes to accumulator; only zero flag updates.
// - Register minus accumulator, addresses 0 to 127; updates carry, nibble and zero flags.
// - For register ops, target bit 0 writes accumulator, 1 writes the register.
// - Accumulator XOR register; only the zero flag updates.
// - Nibble exchange of register swaps halves, flags untouched, target bit picks destination.
module bsxa_alu
  import bsxa_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire bsxa_pkg::bsxa_cmd_t cmd,
  input  wire bsxa_pkg::bsxa_wb_t  host_wr,
  output logic [7:0]               acc_ff,
  output bsxa_pkg::bsxa_flags_t    flags_ff,
  output bsxa_pkg::bsxa_wb_t       wb_ff,
  output logic                     done_ff,
  output logic [7:0]               reg_rd_ff
);

  typedef enum logic [1:0] {
    BSXA_IDLE,
    BSXA_FETCH,
    BSXA_EXEC
  } bsxa_state_t;

  bsxa_state_t  state_ff;
  bsxa_state_t  nxt_state;
  bsxa_cmd_t    hold_ff;
  bsxa_cmd_t    nxt_hold;
  logic [7:0]   nxt_acc;
  bsxa_flags_t  nxt_flags;
  bsxa_wb_t     nxt_wb;
  logic         nxt_done;
  logic [7:0]   nxt_reg_rd;
  logic [7:0]   opnd_data;
  bsxa_wb_t     mem_wr;
  logic [8:0]   diff;
  logic [4:0]   diff_lo;
  logic [7:0]   minuend;
  logic [7:0]   result;
  logic         is_reg_op;

  // Host writes share the port whenever wb_ff.wr_en is low; slice results win otherwise.
  always_comb begin
    mem_wr = wb_ff.wr_en ? wb_ff : host_wr;
  end

  // The read starts on the accept edge from the live command, so the operand stands by the execute cycle.
  bsxa_regfile bsxa_regfile_i (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .wr         (mem_wr),
    .rd_addr    (cmd.valid && state_ff == BSXA_IDLE ? cmd.reg_addr : hold_ff.reg_addr),
    .rd_data_ff (opnd_data)
  );

  always_comb begin
    is_reg_op = (hold_ff.op == BSXA_OP_SUB_REG) || (hold_ff.op == BSXA_OP_XOR_REG) ||
                (hold_ff.op == BSXA_OP_SWAP);
    minuend   = (hold_ff.op == BSXA_OP_SUB_LIT) ? hold_ff.literal_value : opnd_data;
    // Inverted borrow: bit 8 set means no borrow out of bit 7.
    diff      = {1'b0, minuend} + {1'b0, ~acc_ff} + 9'h001;
    diff_lo   = {1'b0, minuend[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
    unique case (hold_ff.op)
      BSXA_OP_SUB_LIT,
      BSXA_OP_SUB_REG: result = diff[7:0];
      BSXA_OP_XOR_LIT: result = acc_ff ^ hold_ff.literal_value;
      BSXA_OP_XOR_REG: result = acc_ff ^ opnd_data;
      BSXA_OP_SWAP:    result = {opnd_data[NIB_LO:0], opnd_data[DATA_W-1:NIB_HI]};
      default:         result = acc_ff;
    endcase
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_hold   = hold_ff;
    nxt_acc    = acc_ff;
    nxt_flags  = flags_ff;
    nxt_wb     = '0;
    nxt_done   = 1'b0;
    nxt_reg_rd = reg_rd_ff;
    unique case (state_ff)
      BSXA_IDLE: begin
        if (cmd.valid && cmd.op != BSXA_OP_NONE) begin
          nxt_hold  = cmd;
          nxt_state = BSXA_FETCH;
        end
      end
      BSXA_FETCH: begin
        nxt_state = BSXA_EXEC;
      end
      BSXA_EXEC: begin
        nxt_state = BSXA_IDLE;
        nxt_done  = 1'b1;
        if (is_reg_op) begin
          nxt_reg_rd = opnd_data;
        end
        if (is_reg_op && hold_ff.target_bit) begin
          nxt_wb.wr_en = 1'b1;
          nxt_wb.addr  = hold_ff.reg_addr;
          nxt_wb.data  = result;
        end else begin
          nxt_acc = result;
        end
        unique case (hold_ff.op)
          BSXA_OP_SUB_LIT,
          BSXA_OP_SUB_REG: begin
            nxt_flags.arith_out_flag    = diff[8];
            nxt_flags.nibble_flag       = diff_lo[4];
            nxt_flags.all_bits_low_flag = (diff[7:0] == 8'h00);
          end
          BSXA_OP_XOR_LIT,
          BSXA_OP_XOR_REG: begin
            nxt_flags.all_bits_low_flag = (result == 8'h00);
          end
          default: begin
            nxt_flags = flags_ff;
          end
        endcase
      end
      default: begin
        nxt_state = BSXA_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= BSXA_IDLE;
      hold_ff   <= '0;
      acc_ff    <= ACC_RST;
      flags_ff  <= FLAGS_RST;
      wb_ff     <= '0;
      done_ff   <= 1'b0;
      reg_rd_ff <= ACC_RST;
    end else begin
      state_ff  <= nxt_state;
      hold_ff   <= nxt_hold;
      acc_ff    <= nxt_acc;
      flags_ff  <= nxt_flags;
      wb_ff     <= nxt_wb;
      done_ff   <= nxt_done;
      reg_rd_ff <= nxt_reg_rd;
    end
  end

  a_sub_lit_result: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_LIT |=>
      acc_ff == 8'(hold_ff.literal_value - $past(acc_ff)))
    else $error("literal subtract result wrong");

  a_xor_lit_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_XOR_LIT |=>
      flags_ff.arith_out_flag == $past(flags_ff.arith_out_flag) &&
      flags_ff.nibble_flag == $past(flags_ff.nibble_flag) &&
      flags_ff.all_bits_low_flag == (acc_ff == 8'h00))
    else $error("literal xor flags wrong");

  a_sub_reg_carry: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_REG |=>
      flags_ff.arith_out_flag == ($past(opnd_data) >= $past(acc_ff)))
    else $error("register subtract carry wrong");

  a_target_reg_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && is_reg_op && hold_ff.target_bit |=>
      wb_ff.wr_en && acc_ff == $past(acc_ff))
    else $error("register destination not honoured");

  a_target_acc_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && !hold_ff.target_bit |=> !wb_ff.wr_en)
    else $error("accumulator destination wrote register");

  a_xor_reg_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_XOR_REG && !hold_ff.target_bit |=>
      acc_ff == ($past(acc_ff) ^ reg_rd_ff))
    else $error("register xor result wrong");

  a_swap_flags_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SWAP |=>
      $stable(flags_ff) && (wb_ff.wr_en ? wb_ff.data : acc_ff) == {reg_rd_ff[3:0], reg_rd_ff[7:4]})
    else $error("nibble exchange wrong");

  a_nibble_borrow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_LIT |=>
      flags_ff.nibble_flag == (hold_ff.literal_value[3:0] >= $past(acc_ff[3:0])))
    else $error("nibble flag wrong");

  a_done_timing: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_IDLE && cmd.valid && cmd.op != BSXA_OP_NONE |-> ##3 done_ff)
    else $error("done not three cycles after accept");

  a_sub_reg_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_REG |=>
      (wb_ff.wr_en ? wb_ff.data : acc_ff) == 8'($past(opnd_data) - $past(acc_ff)))
    else $error("register subtract result wrong");

  a_xor_reg_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_XOR_REG |=>
      $stable(flags_ff.arith_out_flag) && $stable(flags_ff.nibble_flag) &&
      flags_ff.all_bits_low_flag == (($past(acc_ff) ^ $past(opnd_data)) == 8'h00))
    else $error("register xor flags wrong");

  // Outside the execute cycle nothing may touch the accumulator, so refused commands leave no trace.
  a_acc_held_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff != BSXA_EXEC |=> $stable(acc_ff))
    else $error("accumulator changed outside execute");

  a_wb_one_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wb_ff.wr_en |=> !wb_ff.wr_en)
    else $error("writeback strobe longer than one cycle");

  c_sub_lit: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_LIT);
  c_sub_reg_wb: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SUB_REG && hold_ff.target_bit);
  c_swap_acc: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_SWAP && !hold_ff.target_bit);
  c_xor_zero: cover property (@(posedge sys_clk) disable iff (!reset_n)
    done_ff && flags_ff.all_bits_low_flag);
  c_xor_reg_wb: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_ff == BSXA_EXEC && hold_ff.op == BSXA_OP_XOR_REG && hold_ff.target_bit);

endmodule

/* verif/bsxa_alu_tb.sv */
module bsxa_alu_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bsxa_pkg::*;
  logic        sys_clk;
  logic        reset_n;
  bsxa_cmd_t   cmd;
  bsxa_wb_t    host_wr;
  logic [7:0]  acc_ff;
  bsxa_flags_t flags_ff;
  bsxa_wb_t    wb_ff;
  logic        done_ff;
  logic [7:0]  reg_rd_ff;
  int          n_mismatch;
  int          checks;
  int          cycles;
  logic [7:0]  mem [128];
  logic [7:0]  e_acc;
  bsxa_flags_t e_flg;

  bsxa_alu bsxa_alu_i (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd), .host_wr(host_wr), .acc_ff(acc_ff),
    .flags_ff(flags_ff), .wb_ff(wb_ff), .done_ff(done_ff), .reg_rd_ff(reg_rd_ff));

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Far above the roughly 94 cycles that the sequence needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic preload(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_wr = '{1'h1, a, d};
    mem[a] = d;
    @(negedge sys_clk);
    host_wr.wr_en = 1'h0;
  endtask

  // Works out the result from the mirror, issues the command and judges the answer.
  task automatic run(input bsxa_op_t op, input logic [7:0] lit, input logic [6:0] a, input logic t);
    logic [7:0] src;
    logic [7:0] r;
    logic       w;
    logic       lop;
    int         n;
    lop = (op == BSXA_OP_SUB_LIT || op == BSXA_OP_XOR_LIT);
    src = lop ? lit : mem[a];
    w = t && !lop;
    case (op)
      BSXA_OP_SUB_LIT, BSXA_OP_SUB_REG: begin
        r = src - e_acc;
        e_flg = '{src >= e_acc, src[3:0] >= e_acc[3:0], r == 8'h00};
      end
      BSXA_OP_SWAP: r = {src[3:0], src[7:4]};
      default: begin
        r = src ^ e_acc;
        e_flg.all_bits_low_flag = (r == 8'h00);
      end
    endcase
    @(negedge sys_clk);
    cmd = '{1'h1, op, lit, a, t};
    @(negedge sys_clk);
    cmd.valid = 1'h0;
    n = 1;
    while (done_ff !== 1'h1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("latency", 8'h03, 8'(n));
    if (w) mem[a] = r;
    else e_acc = r;
    chk("acc", e_acc, acc_ff);
    chk("flags", {5'h00, e_flg}, {5'h00, flags_ff});
    chk("wb_en", {7'h00, w}, {7'h00, wb_ff.wr_en});
    if (w) chk("wb_data", r, wb_ff.data);
    if (w) chk("wb_addr", {1'h0, a}, {1'h0, wb_ff.addr});
    if (!lop) chk("operand", src, reg_rd_ff);
    @(negedge sys_clk);
    chk("done_end", 8'h00, {7'h00, done_ff});
  endtask

  task automatic t_reset();
    chk("acc", ACC_RST, acc_ff);
    chk("flags", {5'h00, FLAGS_RST}, {5'h00, flags_ff});
    chk("done", 8'h00, {7'h00, done_ff});
    chk("wb_en_rst", 8'h00, {7'h00, wb_ff.wr_en});
    chk("reg_rd_rst", 8'h00, reg_rd_ff);
  endtask

  // A command with no operation, and one raised while busy, must both be ignored.
  task automatic t_refuse();
    int n;
    @(negedge sys_clk);
    cmd = '{1'h1, BSXA_OP_NONE, 8'h33, 7'h00, 1'h0};
    n = 0;
    repeat (4) begin
      @(negedge sys_clk);
      if (done_ff === 1'h1) n++;
    end
    chk("none_done", 8'h00, 8'(n));
    chk("none_acc", e_acc, acc_ff);
    e_acc = e_acc ^ 8'h0f;
    e_flg.all_bits_low_flag = (e_acc == 8'h00);
    cmd = '{1'h1, BSXA_OP_XOR_LIT, 8'h0f, 7'h00, 1'h0};
    @(negedge sys_clk);
    cmd.literal_value = 8'hf0;
    @(negedge sys_clk);
    cmd.valid = 1'h0;
    @(negedge sys_clk);
    chk("busy_done", 8'h01, {7'h00, done_ff});
    chk("busy_acc", e_acc, acc_ff);
    chk("busy_flags", {5'h00, e_flg}, {5'h00, flags_ff});
    // A literal operation ignores the target bit and still writes the accumulator.
    run(BSXA_OP_XOR_LIT, 8'h5a, 7'h00, 1'h1);
  endtask

  // Storage keeps its contents across reset, so the mirror stays valid after it.
  task automatic t_mid_reset();
    @(negedge sys_clk);
    reset_n = 1'h0;
    @(negedge sys_clk);
    t_reset();
    reset_n = 1'h1;
    e_acc = ACC_RST;
    e_flg = FLAGS_RST;
    run(BSXA_OP_SUB_REG, 8'h00, 7'h7f, 1'h0);
  endtask

  task automatic t_sub_lit();
    run(BSXA_OP_SUB_LIT, 8'h00, 7'h00, 1'h0);
    run(BSXA_OP_SUB_LIT, 8'h13, 7'h00, 1'h0);
    run(BSXA_OP_SUB_LIT, 8'h02, 7'h00, 1'h0);
  endtask

  task automatic t_xor_lit();
    run(BSXA_OP_XOR_LIT, 8'hef, 7'h00, 1'h0);
    run(BSXA_OP_XOR_LIT, 8'ha5, 7'h00, 1'h0);
  endtask

  task automatic t_sub_reg();
    preload(7'h7f, 8'hb9);
    preload(7'h00, 8'h05);
    run(BSXA_OP_SUB_REG, 8'h00, 7'h7f, 1'h0);
    run(BSXA_OP_SUB_REG, 8'h00, 7'h00, 1'h1);
  endtask

  task automatic t_xor_reg();
    preload(7'h2a, 8'h14);
    run(BSXA_OP_XOR_REG, 8'h00, 7'h2a, 1'h0);
    run(BSXA_OP_XOR_REG, 8'h00, 7'h00, 1'h1);
  endtask

  task automatic t_swap();
    run(BSXA_OP_SWAP, 8'h00, 7'h00, 1'h0);
    run(BSXA_OP_SWAP, 8'h00, 7'h7f, 1'h1);
    // Reading the swapped register back proves that the writeback landed.
    run(BSXA_OP_SUB_REG, 8'h00, 7'h7f, 1'h0);
  endtask

  initial begin
    reset_n = 1'h0;
    cmd = '0;
    host_wr = '0;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    e_acc = 8'h00;
    e_flg = '0;
    repeat (8) @(negedge sys_clk);
    t_reset();
    reset_n = 1'h1;
    t_sub_lit();
    t_xor_lit();
    t_sub_reg();
    t_xor_reg();
    t_swap();
    t_refuse();
    t_mid_reset();
    summarize();
  end
endmodule
